// ### pin_sync.v
// Three-stage synchroniser for one asynchronous pin.
// Assumes the pin idles high; the output moves only when stages two and three agree.
`timescale 1ns/10ps

module pin_sync (
    input wire clk,
    input wire rst,
    input wire pinIn,
    output reg pinOut
);

reg stage1_q;
reg stage2_q;
reg stage3_q;

always @(posedge clk) begin
    if (rst) begin
        stage1_q <= 1'b1;
        stage2_q <= 1'b1;
        stage3_q <= 1'b1;
        pinOut <= 1'b1;
    end else begin
        stage1_q <= pinIn;
        stage2_q <= stage1_q;
        stage3_q <= stage2_q;
        if (stage2_q == stage3_q) begin
            pinOut <= stage2_q;
        end
    end
end

endmodule

// ### sci_break_asserts.sv
// Concurrent checks on the register port and transmit pin direction of the serial core.
// Assumes a bind to sci_break_ninth_bit_ctrl; only its ports are visible here.
`timescale 1ns/10ps

module sci_break_asserts (
    input wire logic clk,
    input wire logic rst,
    input wire logic [4:0] awaddr,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic [4:0] araddr,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic txdOe,
    input wire logic irq
);
    logic [3:0] sinceAw_q;
    logic [3:0] sinceAw_d;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // ----------------------------------------
    // Cycles since the last write address
    // ----------------------------------------
    always_comb begin
        sinceAw_d = sinceAw_q;
        if (awvalid && awready) begin
            sinceAw_d = 4'h0;
        end else if (sinceAw_q != 4'hF) begin
            sinceAw_d = sinceAw_q + 4'h1;
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            sinceAw_q <= 4'hF;
        end else begin
            sinceAw_q <= sinceAw_d;
        end
    end

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    property p_bAfterAw;
        awvalid && awready && wvalid && wready |=> !awready && !wready ##1 bvalid;
    endproperty
    property p_rAfterAr;
        arvalid && arready |=> rvalid && !arready;
    endproperty
    property p_bHold;
        bvalid && !bready |=> bvalid && $stable(bresp);
    endproperty
    property p_rHold;
        rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp);
    endproperty
    property p_bDone;
        bvalid && bready |=> !bvalid && awready && wready;
    endproperty
    property p_badRead;
        arvalid && arready && araddr[4:2] == 3'h7 |=> rresp == 2'h2 && rdata == 32'h0;
    endproperty
    property p_badWrite;
        awvalid && awready && wvalid && wready && awaddr[4:2] == 3'h7 |=> ##1 bresp == 2'h2;
    endproperty
    property p_okRead;
        arvalid && arready && araddr <= 5'h18 |=> rresp == 2'h0;
    endproperty
    property p_oeMoves;
        $changed(txdOe) |-> sinceAw_q < 4'h5;
    endproperty

    a_bAfterAw: assert property (p_bAfterAw) else $error("write response late");
    a_rAfterAr: assert property (p_rAfterAr) else $error("read response late");
    a_bHold: assert property (p_bHold) else $error("write response dropped");
    a_rHold: assert property (p_rHold) else $error("read data unstable");
    a_bDone: assert property (p_bDone) else $error("write channel not freed");
    a_badRead: assert property (p_badRead) else $error("unmapped read not refused");
    a_badWrite: assert property (p_badWrite) else $error("unmapped write not refused");
    a_okRead: assert property (p_okRead) else $error("mapped read refused");
    a_oeMoves: assert property (p_oeMoves) else $error("pin direction moved alone");
    c_write: cover property (bvalid && bready);
    c_read: cover property (rvalid && rready);
    c_pinIn: cover property (!txdOe);
    c_irq: cover property (irq);
endmodule

bind sci_break_ninth_bit_ctrl sci_break_asserts sci_break_asserts_inst (
    .clk(clk), .rst(rst), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .txdOe(txdOe), .irq(irq)
);

// ### sci_break_defines.vh
// Register offsets, field positions, reset values and counts for the serial block.
// Assumes a 32-bit AXI4-Lite register port, byte addresses, one aligned word per register.
`ifndef SCI_BREAK_DEFINES_VH
`define SCI_BREAK_DEFINES_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define SCI_OFS_CTRL 5'h00
`define SCI_OFS_STATUS_TWO 5'h04
`define SCI_OFS_NINTH_DIR 5'h08
`define SCI_OFS_DATA 5'h0C
`define SCI_OFS_IRQ_STAT 5'h10
`define SCI_OFS_IRQ_MASK 5'h14
`define SCI_OFS_BAUD 5'h18

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define SCI_CTRL_NINE 0
`define SCI_CTRL_INV 1
`define SCI_CTRL_LOOP 2
`define SCI_CTRL_RECEIVER_SOURCE_SELECT 3
`define SCI_CTRL_RXEN 4
`define SCI_CTRL_TXEN 5
`define SCI_CTRL_TXBUSY 7
`define SCI_S2_RAF 0
`define SCI_S2_LONG_BREAK_DETECT_ENABLE 1
`define SCI_C3_SINGLE_WIRE_PIN_DIRECTION 5
`define SCI_C3_T8 6
`define SCI_C3_R8 7
`define SCI_IRQ_RXFULL 0
`define SCI_IRQ_FRAMERR 1
`define SCI_IRQ_BREAK 2
`define SCI_IRQ_TXDONE 3

// ----------------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------------
`define SCI_CTRL_RST 6'h00
`define SCI_BAUD_RST 16'h0364
`define SCI_BAUD_MIN 16'h0002
`define SCI_BREAK_SHORT 4'hA
`define SCI_DATA_BITS 4'h8
`define SCI_FRAME_BITS 4'hA
`define SCI_RESP_OKAY 2'h0
`define SCI_RESP_SLVERR 2'h2

`endif

// ### sci_break_ninth_bit_ctrl.v
// Serial interface core: break detection, receiver-active flag, input inversion,
// ninth data bit and single-wire pin direction, with an AXI4-Lite register port.
// Assumes one 100 MHz clock, synchronous active-high reset, idle-high serial line.
`timescale 1ns/10ps
`include "sci_break_defines.vh"

module sci_break_ninth_bit_ctrl (
    input wire clk,
    input wire rst,
    input wire [4:0] awaddr,
    input wire awvalid,
    output reg awready,
    input wire [31:0] wdata,
    input wire [3:0] wstrb,
    input wire wvalid,
    output reg wready,
    output reg [1:0] bresp,
    output reg bvalid,
    input wire bready,
    input wire [4:0] araddr,
    input wire arvalid,
    output reg arready,
    output reg [31:0] rdata,
    output reg [1:0] rresp,
    output reg rvalid,
    input wire rready,
    input wire rxdIn,
    input wire txdIn,
    output reg txdOut,
    output reg txdOe,
    output reg irq
);

// ----------------------------------------------------------------------
// States and helpers
// ----------------------------------------------------------------------
localparam RX_IDLE = 3'd0;
localparam RX_START = 3'd1;
localparam RX_DATA = 3'd2;
localparam RX_STOP = 3'd3;
localparam RX_BREAK = 3'd4;
localparam RX_WAITHIGH = 3'd5;

function [3:0] breakBits;
    input nine;
    input longBreak;
    begin
        breakBits = `SCI_BREAK_SHORT + {3'b000, nine} + {3'b000, longBreak};
    end
endfunction

function [3:0] frameBits;
    input nine;
    begin
        frameBits = `SCI_FRAME_BITS + {3'b000, nine};
    end
endfunction

// ----------------------------------------------------------------------
// Registers
// ----------------------------------------------------------------------
reg [5:0] ctrl_q;
reg longBreak_q;
reg txNinth_q;
reg pinDir_q;
reg [15:0] baud_q;
reg [3:0] irqStat_q;
reg [3:0] irqMask_q;
reg rxNinth_q;
reg [7:0] rxData_q;
reg active_q;

reg awHeld_q;
reg [4:0] awAddr_q;
reg wHeld_q;
reg [31:0] wData_q;
reg [3:0] wStrb_q;

wire nine = ctrl_q[`SCI_CTRL_NINE];
wire singleWire = ctrl_q[`SCI_CTRL_LOOP] & ctrl_q[`SCI_CTRL_RECEIVER_SOURCE_SELECT];
wire [15:0] bitDiv = (baud_q < `SCI_BAUD_MIN) ? `SCI_BAUD_MIN : baud_q;
wire wrEn = awHeld_q & wHeld_q & ~bvalid;
wire [4:0] wrAddr = {awAddr_q[4:2], 2'b00};
wire wrLow = wrEn & wStrb_q[0];
wire rdTake = arvalid & arready;
wire [4:0] rdAddr = {araddr[4:2], 2'b00};
wire dataRead = rdTake & (rdAddr == `SCI_OFS_DATA);

// ----------------------------------------------------------------------
// Receive input selection
// ----------------------------------------------------------------------
wire rxPinSync;
wire txPinSync;
reg txLine_q;
reg [2:0] rxState_q;

pin_sync rxSyncInst (
    .clk(clk),
    .rst(rst),
    .pinIn(rxdIn),
    .pinOut(rxPinSync)
);

pin_sync txSyncInst (
    .clk(clk),
    .rst(rst),
    .pinIn(txdIn),
    .pinOut(txPinSync)
);

reg rxSource;
always @* begin
    if (!ctrl_q[`SCI_CTRL_LOOP]) begin
        rxSource = rxPinSync;
    end else if (ctrl_q[`SCI_CTRL_RECEIVER_SOURCE_SELECT]) begin
        rxSource = txPinSync;
    end else begin
        rxSource = txLine_q;
    end
end

wire rxLine = rxSource ^ ctrl_q[`SCI_CTRL_INV];

// ----------------------------------------------------------------------
// Receiver
// ----------------------------------------------------------------------
reg [15:0] rxCnt_q;
reg [3:0] bitIdx_q;
reg [3:0] lowCnt_q;
reg [3:0] idleCnt_q;
reg [8:0] rxShift_q;
reg prevLine_q;
reg setFull;
reg setFrame;
reg setBreak;

wire rxTick = (rxCnt_q == 16'h0000);
wire [3:0] lowNext = rxLine ? 4'h0 : lowCnt_q + 4'h1;
wire [3:0] breakNeed = breakBits(nine, longBreak_q);

always @(posedge clk) begin
    if (rst) begin
        rxState_q <= RX_IDLE;
        rxCnt_q <= 16'h0000;
        bitIdx_q <= 4'h0;
        lowCnt_q <= 4'h0;
        idleCnt_q <= 4'h0;
        rxShift_q <= 9'h000;
        prevLine_q <= 1'b1;
        active_q <= 1'b0;
        rxData_q <= 8'h00;
        rxNinth_q <= 1'b0;
        setFull <= 1'b0;
        setFrame <= 1'b0;
        setBreak <= 1'b0;
    end else begin
        prevLine_q <= rxLine;
        setFull <= 1'b0;
        setFrame <= 1'b0;
        setBreak <= 1'b0;
        rxCnt_q <= rxTick ? bitDiv - 16'h0001 : rxCnt_q - 16'h0001;
        case (rxState_q)
            RX_IDLE: begin
                if (rxTick && rxLine && active_q) begin
                    if (idleCnt_q + 4'h1 >= frameBits(nine)) begin
                        active_q <= 1'b0;
                        idleCnt_q <= 4'h0;
                    end else begin
                        idleCnt_q <= idleCnt_q + 4'h1;
                    end
                end
                if (ctrl_q[`SCI_CTRL_RXEN] && prevLine_q && !rxLine) begin
                    rxState_q <= RX_START;
                    rxCnt_q <= {1'b0, bitDiv[15:1]};
                    // Low run restarts at each start bit
                    lowCnt_q <= 4'h0;
                    idleCnt_q <= 4'h0;
                    active_q <= 1'b1;
                end
            end
            RX_START: begin
                if (rxTick) begin
                    lowCnt_q <= lowNext;
                    bitIdx_q <= 4'h0;
                    rxState_q <= rxLine ? RX_IDLE : RX_DATA;
                end
            end
            RX_DATA: begin
                if (rxTick) begin
                    lowCnt_q <= lowNext;
                    rxShift_q <= {rxLine, rxShift_q[8:1]};
                    bitIdx_q <= bitIdx_q + 4'h1;
                    if (bitIdx_q + 4'h1 == `SCI_DATA_BITS + {3'b000, nine}) begin
                        rxState_q <= RX_STOP;
                    end
                end
            end
            RX_STOP: begin
                if (rxTick) begin
                    lowCnt_q <= lowNext;
                    if (nine) begin
                        rxData_q <= rxShift_q[7:0];
                        rxNinth_q <= rxShift_q[8];
                    end else begin
                        rxData_q <= rxShift_q[8:1];
                        rxNinth_q <= 1'b0;
                    end
                    setFull <= ~longBreak_q;
                    setFrame <= ~longBreak_q & ~rxLine;
                    if (!rxLine && lowNext >= breakNeed) begin
                        setBreak <= 1'b1;
                        rxState_q <= RX_WAITHIGH;
                    end else if (!rxLine && lowNext == frameBits(nine)) begin
                        rxState_q <= RX_BREAK;
                    end else begin
                        rxState_q <= RX_WAITHIGH;
                    end
                end
            end
            RX_BREAK: begin
                if (rxTick) begin
                    lowCnt_q <= lowNext;
                    if (rxLine) begin
                        rxState_q <= RX_WAITHIGH;
                    end else if (lowNext >= breakNeed) begin
                        setBreak <= 1'b1;
                        rxState_q <= RX_WAITHIGH;
                    end
                end
            end
            RX_WAITHIGH: begin
                if (rxLine) begin
                    rxState_q <= RX_IDLE;
                    idleCnt_q <= 4'h0;
                end
            end
            default: begin
                rxState_q <= RX_IDLE;
            end
        endcase
    end
end

// ----------------------------------------------------------------------
// Transmitter
// ----------------------------------------------------------------------
reg [10:0] txShift_q;
reg [3:0] txBits_q;
reg [15:0] txCnt_q;
reg txDone;

wire txBusy = (txBits_q != 4'h0);
wire txLoad = wrLow & (wrAddr == `SCI_OFS_DATA) & ctrl_q[`SCI_CTRL_TXEN] & ~txBusy;

always @(posedge clk) begin
    if (rst) begin
        txShift_q <= 11'h7FF;
        txBits_q <= 4'h0;
        txCnt_q <= 16'h0000;
        txLine_q <= 1'b1;
        txDone <= 1'b0;
    end else begin
        txDone <= 1'b0;
        if (txLoad) begin
            // Ninth bit taken from its held register at load time
            txShift_q <= {1'b1, nine ? txNinth_q : 1'b1, wData_q[7:0], 1'b0};
            txBits_q <= frameBits(nine);
            txCnt_q <= bitDiv - 16'h0001;
        end else if (txBusy) begin
            if (txCnt_q == 16'h0000) begin
                txCnt_q <= bitDiv - 16'h0001;
                txShift_q <= {1'b1, txShift_q[10:1]};
                txBits_q <= txBits_q - 4'h1;
                txDone <= (txBits_q == 4'h1);
            end else begin
                txCnt_q <= txCnt_q - 16'h0001;
            end
        end
        txLine_q <= txBusy ? txShift_q[0] : 1'b1;
    end
end

// ----------------------------------------------------------------------
// Register writes, flags and pins
// ----------------------------------------------------------------------
wire [3:0] irqSet = {txDone, setBreak, setFrame, setFull};
wire [3:0] irqClr = (wrLow && wrAddr == `SCI_OFS_IRQ_STAT) ? wData_q[3:0] : 4'h0;
wire [3:0] readClr = {3'b000, dataRead};

always @(posedge clk) begin
    if (rst) begin
        ctrl_q <= `SCI_CTRL_RST;
        longBreak_q <= 1'b0;
        txNinth_q <= 1'b0;
        pinDir_q <= 1'b0;
        baud_q <= `SCI_BAUD_RST;
        irqStat_q <= 4'h0;
        irqMask_q <= 4'h0;
        irq <= 1'b0;
        txdOut <= 1'b1;
        txdOe <= 1'b1;
    end else begin
        if (wrLow) begin
            case (wrAddr)
                `SCI_OFS_CTRL: ctrl_q <= wData_q[5:0];
                `SCI_OFS_STATUS_TWO: longBreak_q <= wData_q[`SCI_S2_LONG_BREAK_DETECT_ENABLE];
                `SCI_OFS_NINTH_DIR: begin
                    // Received ninth bit is not writable
                    txNinth_q <= wData_q[`SCI_C3_T8];
                    pinDir_q <= wData_q[`SCI_C3_SINGLE_WIRE_PIN_DIRECTION];
                end
                `SCI_OFS_IRQ_MASK: irqMask_q <= wData_q[3:0];
                `SCI_OFS_BAUD: baud_q[7:0] <= wData_q[7:0];
                default: begin
                end
            endcase
        end
        if (wrEn && wStrb_q[1] && wrAddr == `SCI_OFS_BAUD) begin
            baud_q[15:8] <= wData_q[15:8];
        end
        // Hardware set wins over software clear
        irqStat_q <= (irqStat_q & ~(irqClr | readClr)) | irqSet;
        irq <= |(irqStat_q & irqMask_q);
        txdOut <= txLine_q;
        txdOe <= singleWire ? pinDir_q : 1'b1;
    end
end

// ----------------------------------------------------------------------
// AXI4-Lite slave
// ----------------------------------------------------------------------
reg [31:0] readMux;
reg readOk;
always @* begin
    readMux = 32'h00000000;
    readOk = 1'b1;
    case (rdAddr)
        `SCI_OFS_CTRL: readMux = {24'h000000, txBusy, 1'b0, ctrl_q};
        `SCI_OFS_STATUS_TWO: readMux = {30'h00000000, longBreak_q, active_q};
        `SCI_OFS_NINTH_DIR: readMux = {24'h000000, rxNinth_q, txNinth_q, pinDir_q, 5'h00};
        `SCI_OFS_DATA: readMux = {24'h000000, rxData_q};
        `SCI_OFS_IRQ_STAT: readMux = {28'h0000000, irqStat_q};
        `SCI_OFS_IRQ_MASK: readMux = {28'h0000000, irqMask_q};
        `SCI_OFS_BAUD: readMux = {16'h0000, baud_q};
        default: readOk = 1'b0;
    endcase
end

wire wrOk = (wrAddr <= `SCI_OFS_BAUD);

always @(posedge clk) begin
    if (rst) begin
        awready <= 1'b1;
        wready <= 1'b1;
        awHeld_q <= 1'b0;
        wHeld_q <= 1'b0;
        awAddr_q <= 5'h00;
        wData_q <= 32'h00000000;
        wStrb_q <= 4'h0;
        bvalid <= 1'b0;
        bresp <= `SCI_RESP_OKAY;
        arready <= 1'b1;
        rvalid <= 1'b0;
        rdata <= 32'h00000000;
        rresp <= `SCI_RESP_OKAY;
    end else begin
        if (awvalid && awready) begin
            awHeld_q <= 1'b1;
            awAddr_q <= awaddr;
            awready <= 1'b0;
        end
        if (wvalid && wready) begin
            wHeld_q <= 1'b1;
            wData_q <= wdata;
            wStrb_q <= wstrb;
            wready <= 1'b0;
        end
        if (wrEn) begin
            awHeld_q <= 1'b0;
            wHeld_q <= 1'b0;
            bvalid <= 1'b1;
            bresp <= wrOk ? `SCI_RESP_OKAY : `SCI_RESP_SLVERR;
        end
        if (bvalid && bready) begin
            bvalid <= 1'b0;
            awready <= 1'b1;
            wready <= 1'b1;
        end
        if (rdTake) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= readMux;
            rresp <= readOk ? `SCI_RESP_OKAY : `SCI_RESP_SLVERR;
        end
        if (rvalid && rready) begin
            rvalid <= 1'b0;
            arready <= 1'b1;
        end
    end
end

endmodule

// ### serial_peer.sv
// Remote serial node: sends frames and breaks, captures frames from the transmit pin.
// Assumes a fixed bit time in clock cycles, matching the divisor set by the bench.
`timescale 1ns/10ps

module serial_peer #(
    parameter int BIT = 8
) (
    input wire logic clk,
    input wire logic txdOut,
    input wire logic txdOe,
    output logic rxLine
);
    logic inv = 1'b0;
    logic rxNine = 1'b1;
    logic busy = 1'b0;
    logic [8:0] rxWord = 9'h000;
    int rxCount = 0;
    initial rxLine = 1'b1;

    // ----------------------------------------
    // Sending side
    // ----------------------------------------
    task automatic drive(input logic lvl, input int bits);
        rxLine <= lvl ^ inv;
        repeat (bits * BIT) @(posedge clk);
    endtask
    task automatic sendFrame(input logic [8:0] v, input logic nine);
        busy = 1'b1;
        drive(1'b0, 1);
        for (int i = 0; i < (nine ? 9 : 8); i++) begin
            drive(v[i], 1);
        end
        // Stop bit plus one idle bit, so the frame is stored before return
        drive(1'b1, 2);
        busy = 1'b0;
    endtask

    // ----------------------------------------
    // Receiving side
    // ----------------------------------------
    always begin
        @(negedge txdOut);
        if (txdOe) begin
            repeat (BIT / 2) @(posedge clk);
            for (int i = 0; i < 9; i++) begin
                repeat (BIT) @(posedge clk);
                if (i < 8 || rxNine) rxWord[i] = txdOut; // Ninth bit last
            end
            rxCount++;
        end
    end
endmodule

// ### tb.sv
// Self-checking bench for the serial core: register port, receive flags, break, ninth bit.
// Assumes the core at 100 MHz and a remote serial node on the receive pin.
`timescale 1ns/10ps
`include "sci_break_defines.vh"

module tb;
    localparam int BIT = 8;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [4:0] awaddr = 5'h00;
    logic [4:0] araddr = 5'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, txdOut, txdOe, irq, rxdIn, txdIn;
    logic [1:0] bresp, rresp, resp;
    logic [31:0] rdata, rd;
    int mismatches = 0, testsRun = 0, cycles = 0, lng, nine;
    logic [3:0] oeCfg [4] = '{4'h3, 4'h7, 4'h1, 4'h2};

    always #5 clk = ~clk;
    assign txdIn = txdOe ? txdOut : 1'b1;

    sci_break_ninth_bit_ctrl sci_break_ninth_bit_ctrl_inst (
        .clk(clk), .rst(rst), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .rxdIn(rxdIn), .txdIn(txdIn), .txdOut(txdOut), .txdOe(txdOe), .irq(irq)
    );
    serial_peer #(.BIT(BIT)) serial_peer_inst (
        .clk(clk), .txdOut(txdOut), .txdOe(txdOe), .rxLine(rxdIn)
    );

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        testsRun++;
        if (seen !== exp) begin
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
            mismatches++;
        end
    endtask
    task automatic axiWrite(input logic [4:0] a, input logic [31:0] d);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!(bvalid && bready));
        resp = bresp;
        bready <= 1'b0;
    endtask
    task automatic axiRead(input logic [4:0] a, output logic [31:0] d);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!(rvalid && rready));
        d = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask
    task automatic expectReg(input logic [4:0] a, input logic [31:0] exp);
        axiRead(a, rd);
        check(rd, exp);
    endtask
    task automatic txWord(input logic [7:0] d, input logic [8:0] exp);
        int cnt;
        cnt = serial_peer_inst.rxCount;
        axiWrite(`SCI_OFS_DATA, {24'h0, d});
        while (serial_peer_inst.rxCount == cnt) @(posedge clk);
        check({23'h0, serial_peer_inst.rxWord}, {23'h0, exp});
        do axiRead(`SCI_OFS_CTRL, rd); while (rd[7] !== 1'b0);
    endtask
    task automatic complete_run;
        if (mismatches == 0 && testsRun > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            mismatches++;
            complete_run;
        end
    end

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        expectReg(`SCI_OFS_CTRL, 32'h0);
        expectReg(`SCI_OFS_BAUD, 32'h364);
        expectReg(`SCI_OFS_IRQ_STAT, 32'h0);
        expectReg(5'h1C, 32'h0);
        check(resp, 2'h2);
        axiWrite(5'h1C, 32'hFF);
        check(resp, 2'h2);
        axiWrite(`SCI_OFS_BAUD, BIT);
        axiWrite(`SCI_OFS_CTRL, 32'h30);
        fork serial_peer_inst.sendFrame(9'h0A5, 1'b0); join_none
        repeat (3 * BIT) @(posedge clk);
        expectReg(`SCI_OFS_STATUS_TWO, 32'h1);
        while (serial_peer_inst.busy) @(posedge clk);
        serial_peer_inst.drive(1'b1, 14);
        expectReg(`SCI_OFS_STATUS_TWO, 32'h0);
        check(irq, 1'b0);
        expectReg(`SCI_OFS_IRQ_STAT, 32'h1);
        axiWrite(`SCI_OFS_IRQ_MASK, 32'hF);
        repeat (3) @(posedge clk);
        check(irq, 1'b1);
        expectReg(`SCI_OFS_DATA, 32'hA5);
        axiWrite(`SCI_OFS_IRQ_STAT, 32'hF);
        repeat (3) @(posedge clk);
        check(irq, 1'b0);
        for (int k = 0; k < 4; k++) begin
            nine = k % 2;
            lng = k / 2;
            axiWrite(`SCI_OFS_CTRL, 32'h30 | nine);
            axiWrite(`SCI_OFS_STATUS_TWO, lng * 2);
            serial_peer_inst.drive(1'b0, 9 + nine + lng);
            serial_peer_inst.drive(1'b1, 14);
            expectReg(`SCI_OFS_IRQ_STAT, lng ? 32'h0 : 32'h1);
            axiWrite(`SCI_OFS_IRQ_STAT, 32'hF);
            serial_peer_inst.drive(1'b0, 10 + nine + lng);
            serial_peer_inst.drive(1'b1, 14);
            expectReg(`SCI_OFS_IRQ_STAT, lng ? 32'h4 : 32'h7);
            axiWrite(`SCI_OFS_IRQ_STAT, 32'hF);
        end
        axiWrite(`SCI_OFS_STATUS_TWO, 32'h1);
        expectReg(`SCI_OFS_STATUS_TWO, 32'h0);
        serial_peer_inst.sendFrame(9'h1C3, 1'b1);
        expectReg(`SCI_OFS_NINTH_DIR, 32'h80);
        expectReg(`SCI_OFS_DATA, 32'hC3);
        serial_peer_inst.sendFrame(9'h05A, 1'b1);
        expectReg(`SCI_OFS_NINTH_DIR, 32'h00);
        expectReg(`SCI_OFS_DATA, 32'h5A);
        axiWrite(`SCI_OFS_NINTH_DIR, 32'h80);
        expectReg(`SCI_OFS_NINTH_DIR, 32'h00);
        axiWrite(`SCI_OFS_NINTH_DIR, 32'h40);
        txWord(8'h96, 9'h196);
        txWord(8'h21, 9'h121);
        expectReg(`SCI_OFS_IRQ_STAT, 32'h8);
        for (int k = 0; k < 4; k++) begin
            axiWrite(`SCI_OFS_CTRL, 32'h30 | (oeCfg[k][1:0] << 2));
            axiWrite(`SCI_OFS_NINTH_DIR, {26'h0, oeCfg[k][2], 5'h0});
            repeat (3) @(posedge clk);
            check(txdOe, k != 0);
        end
        axiWrite(`SCI_OFS_CTRL, 32'h32);
        serial_peer_inst.inv = 1'b1;
        serial_peer_inst.drive(1'b1, 14);
        expectReg(`SCI_OFS_STATUS_TWO, 32'h0);
        axiWrite(`SCI_OFS_IRQ_STAT, 32'hF);
        serial_peer_inst.sendFrame(9'h03C, 1'b0);
        expectReg(`SCI_OFS_IRQ_STAT, 32'h1);
        expectReg(`SCI_OFS_DATA, 32'h3C);
        complete_run;
    end
endmodule
